//--- shared/tcfg_params.svh
// Purpose: Offsets, field positions, reset values and timing counts for the terminal option block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Definitions only.
`ifndef TCFG_PARAMS_SVH
`define TCFG_PARAMS_SVH

`define TCFG_ADDR_W          12
`define TCFG_OFS_OPTION      12'h000
`define TCFG_OFS_AUX         12'h004
`define TCFG_OFS_STATUS      12'h008

`define TCFG_OPTION_RESET    16'h0000
`define TCFG_AUX_RESET       8'h00
`define TCFG_BIT_RETRY2_EN   3

`define TCFG_ST_ADDR_LSB     0
`define TCFG_ST_ADDR_VALID   6
`define TCFG_ST_TEST_LSB     7
`define TCFG_ST_TEST_BAD     10
`define TCFG_ST_GAP_ACTIVE   11

`define TCFG_TEST_NORMAL     3'h0
`define TCFG_TEST_DECODER    3'h1
`define TCFG_TEST_ENCODER    3'h2
`define TCFG_TEST_PROTOCOL   3'h3
`define TCFG_TEST_FAILSAFE   3'h4
`define TCFG_TEST_REGISTERS  3'h5

`define TCFG_CLK_PERIOD_NS   25
`define TCFG_GAP_EXT_NS      20000
`define TCFG_GAP_EXT_CYCLES  ((`TCFG_GAP_EXT_NS + `TCFG_CLK_PERIOD_NS - 1) / `TCFG_CLK_PERIOD_NS)

`endif

//--- shared/tcfg_pkg.sv
// Purpose: Types shared by the terminal option block and its helpers.
// Assumes: Nothing beyond the constants header.
// Notes:   Field order of option_low_t matches the low byte, bit 7 first.
`default_nettype none
package tcfg_pkg;

    typedef enum logic
    {
        BUS_A = 1'b0,
        BUS_B = 1'b1
    } bus_t;

    typedef struct packed
    {
        logic       second_retry_alt_bus;
        logic       msg_error_no_data_valid;
        logic       busy_no_data_valid;
        logic       monitor_alt_bus_gap_keep;
        logic       address_latch_allow;
        logic [2:0] test_select;
    } option_low_t;

    typedef struct packed
    {
        logic [5:0] words_requested;
        logic [5:0] words_received;
        logic       msg_error;
        logic       busy;
    } resp_info_t;

    typedef struct packed
    {
        logic [4:0] rt_addr;
        logic       parity;
    } rt_addr_t;

    typedef enum logic [6:0]
    {
        TM_NORMAL    = 7'h01,
        TM_DECODER   = 7'h02,
        TM_ENCODER   = 7'h04,
        TM_PROTOCOL  = 7'h08,
        TM_FAILSAFE  = 7'h10,
        TM_REGISTERS = 7'h20,
        TM_INVALID   = 7'h40
    } test_mode_t;

endpackage
`default_nettype wire

//--- design/retry_bus_select.sv
// Purpose: Chooses the bus for a second retry of a failed message.
// Assumes: second_retry_req is a one-cycle pulse from the retry engine.
// Notes:   Answers one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module retry_bus_select
(
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // Configuration
    input  wire logic           alt_bus,
    input  wire logic           retry_enable,
    // Request and answer
    input  wire logic           second_retry_req,
    input  wire tcfg_pkg::bus_t orig_bus,
    output logic                second_retry_go,
    output tcfg_pkg::bus_t      second_retry_bus,
    output logic                second_retry_drop
);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            second_retry_go   <= 1'b0;
            second_retry_drop <= 1'b0;
        end
        else
        begin
            second_retry_go   <= second_retry_req & retry_enable;
            second_retry_drop <= second_retry_req & ~retry_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            second_retry_bus <= tcfg_pkg::BUS_A;
        else if (second_retry_req && retry_enable)
            second_retry_bus <= alt_bus ? tcfg_pkg::bus_t'(~orig_bus) : orig_bus;
    end

    AST_RETRY_SAME_BUS: assert property (@(posedge pclk) disable iff (!presetn)
        second_retry_req && retry_enable && !alt_bus |=> second_retry_go && second_retry_bus == $past(orig_bus))
        else $error("Second retry left the original bus.");

    AST_RETRY_ALT_BUS: assert property (@(posedge pclk) disable iff (!presetn)
        second_retry_req && retry_enable && alt_bus |=> second_retry_go && second_retry_bus != $past(orig_bus))
        else $error("Second retry stayed on the original bus.");

    AST_RETRY_NEEDS_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
        second_retry_go |-> $past(retry_enable) && $past(second_retry_req) && !second_retry_drop)
        else $error("Second retry issued without enable.");

endmodule
`default_nettype wire

//--- design/response_validity.sv
// Purpose: Judges an RT response that carries the error or busy status bit.
// Assumes: resp_done is a one-cycle pulse with resp_info valid in the same cycle.
// Notes:   A response with both bits set and no data needs both allowances.
`timescale 1ns/1ps
`default_nettype none
module response_validity
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Configuration
    input  wire logic                 msg_error_no_data_valid,
    input  wire logic                 busy_no_data_valid,
    // Response and verdict
    input  wire logic                 resp_done,
    input  wire tcfg_pkg::resp_info_t resp_info,
    output logic                      resp_valid,
    output logic                      resp_invalid
);

    logic nxt_ok;
    logic full_data;
    logic no_data_ok;

    always_comb
    begin
        full_data  = resp_info.words_received == resp_info.words_requested;
        no_data_ok = resp_info.words_received == 6'h00
                   && (resp_info.msg_error || resp_info.busy)
                   && (!resp_info.msg_error || msg_error_no_data_valid)
                   && (!resp_info.busy || busy_no_data_valid);
        nxt_ok     = full_data || no_data_ok;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            resp_valid   <= 1'b0;
            resp_invalid <= 1'b0;
        end
        else
        begin
            resp_valid   <= resp_done & nxt_ok;
            resp_invalid <= resp_done & ~nxt_ok;
        end
    end

    AST_MERR_NEEDS_DATA: assert property (@(posedge pclk) disable iff (!presetn)
        resp_done && resp_info.msg_error && !msg_error_no_data_valid && resp_info.words_requested != 6'h00
        && resp_info.words_received == 6'h00 |=> resp_invalid && !resp_valid)
        else $error("Error status without data accepted.");

    AST_MERR_NO_DATA_OK: assert property (@(posedge pclk) disable iff (!presetn)
        resp_done && resp_info.msg_error && !resp_info.busy && msg_error_no_data_valid
        && resp_info.words_received == 6'h00 |=> resp_valid)
        else $error("Error status without data refused.");

    AST_BUSY_NEEDS_DATA: assert property (@(posedge pclk) disable iff (!presetn)
        resp_done && resp_info.busy && !busy_no_data_valid && resp_info.words_requested != 6'h00
        && resp_info.words_received == 6'h00 |=> resp_invalid)
        else $error("Busy status without data accepted.");

    AST_BUSY_NO_DATA_OK: assert property (@(posedge pclk) disable iff (!presetn)
        resp_done && resp_info.busy && !resp_info.msg_error && busy_no_data_valid
        && resp_info.words_received == 6'h00 |=> resp_valid)
        else $error("Busy status without data refused.");

endmodule
`default_nettype wire

//--- design/terminal_option_config.sv
// Purpose: Terminal option register with its retry, validity, monitor gap, address latch and test effects.
// Assumes: APB slave with zero wait states; all inputs synchronous to pclk.
// Notes:   The upper byte of the option register is plain storage for logic elsewhere.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "tcfg_params.svh"
`default_nettype none
module terminal_option_config
#(
    parameter int GAP_EXT_CYCLES = `TCFG_GAP_EXT_CYCLES
)
(
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [`TCFG_ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Second retry
    input  wire logic                       second_retry_req,
    input  wire tcfg_pkg::bus_t             orig_bus,
    output logic                            second_retry_go,
    output tcfg_pkg::bus_t                  second_retry_bus,
    output logic                            second_retry_drop,
    // Response validity
    input  wire logic                       resp_done,
    input  wire tcfg_pkg::resp_info_t       resp_info,
    output logic                            resp_valid,
    output logic                            resp_invalid,
    // Monitor gap
    input  wire logic                       monitor_mode,
    input  wire logic                       mon_msg_start,
    input  wire tcfg_pkg::bus_t             mon_msg_bus,
    output logic                            mon_gap_extend,
    // RT address latch
    input  wire logic                       address_latch_input,
    input  wire tcfg_pkg::rt_addr_t         rt_addr_pins,
    output tcfg_pkg::rt_addr_t              rt_addr_latched,
    // Test condition
    output tcfg_pkg::test_mode_t            test_mode
);

    localparam int GAP_W = $clog2(GAP_EXT_CYCLES + 1);

    logic [15:0]            option_ff;
    logic [7:0]             aux_ff;
    logic [31:0]            prdata_ff;
    tcfg_pkg::option_low_t  opt;
    logic                   second_retry_enable;
    logic                   wr_en;
    logic                   rd_setup;
    logic [31:0]            nxt_prdata;

    tcfg_pkg::rt_addr_t     addr_ff;
    logic                   addr_valid_ff;

    tcfg_pkg::bus_t         last_bus_ff;
    logic                   seen_msg_ff;
    logic                   alt_start;
    logic [GAP_W-1:0]       gap_cnt_ff;
    logic                   gap_active_ff;

    tcfg_pkg::test_mode_t   test_mode_ff;

    function automatic logic addr_mapped(input logic [`TCFG_ADDR_W-1:0] a);
        addr_mapped = (a == `TCFG_OFS_OPTION) || (a == `TCFG_OFS_AUX) || (a == `TCFG_OFS_STATUS);
    endfunction

    function automatic tcfg_pkg::test_mode_t test_decode(input logic [2:0] code);
        case (code)
            `TCFG_TEST_NORMAL:    test_decode = tcfg_pkg::TM_NORMAL;
            `TCFG_TEST_DECODER:   test_decode = tcfg_pkg::TM_DECODER;
            `TCFG_TEST_ENCODER:   test_decode = tcfg_pkg::TM_ENCODER;
            `TCFG_TEST_PROTOCOL:  test_decode = tcfg_pkg::TM_PROTOCOL;
            `TCFG_TEST_FAILSAFE:  test_decode = tcfg_pkg::TM_FAILSAFE;
            `TCFG_TEST_REGISTERS: test_decode = tcfg_pkg::TM_REGISTERS;
            default:              test_decode = tcfg_pkg::TM_INVALID;
        endcase
    endfunction

    assign opt                 = tcfg_pkg::option_low_t'(option_ff[7:0]);
    assign second_retry_enable = aux_ff[`TCFG_BIT_RETRY2_EN];

    // APB handshake: every access completes in its first access cycle.
    assign wr_en    = psel & penable & pwrite & addr_mapped(paddr);
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_mapped(paddr);
    assign prdata   = prdata_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            option_ff <= `TCFG_OPTION_RESET;
        else if (wr_en && paddr == `TCFG_OFS_OPTION)
        begin
            if (pstrb[0])
                option_ff[7:0] <= pwdata[7:0];
            if (pstrb[1])
                option_ff[15:8] <= pwdata[15:8];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            aux_ff <= `TCFG_AUX_RESET;
        else if (wr_en && paddr == `TCFG_OFS_AUX && pstrb[0])
            aux_ff <= pwdata[7:0];
    end

    // Read data is captured in the setup cycle so that it comes from a flip-flop
    // and still needs no wait state.
    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            `TCFG_OFS_OPTION:
                nxt_prdata[15:0] = option_ff;
            `TCFG_OFS_AUX:
                nxt_prdata[7:0] = aux_ff;
            `TCFG_OFS_STATUS:
            begin
                nxt_prdata[`TCFG_ST_ADDR_LSB +: 6]  = addr_ff;
                nxt_prdata[`TCFG_ST_ADDR_VALID]     = addr_valid_ff;
                nxt_prdata[`TCFG_ST_TEST_LSB +: 3]  = opt.test_select;
                nxt_prdata[`TCFG_ST_TEST_BAD]       = test_mode_ff == tcfg_pkg::TM_INVALID;
                nxt_prdata[`TCFG_ST_GAP_ACTIVE]     = gap_active_ff;
            end
            default:
                nxt_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (rd_setup)
            prdata_ff <= nxt_prdata;
    end

    retry_bus_select u_retry
    (
        .pclk              (pclk),
        .presetn           (presetn),
        .alt_bus           (opt.second_retry_alt_bus),
        .retry_enable      (second_retry_enable),
        .second_retry_req  (second_retry_req),
        .orig_bus          (orig_bus),
        .second_retry_go   (second_retry_go),
        .second_retry_bus  (second_retry_bus),
        .second_retry_drop (second_retry_drop)
    );

    response_validity u_resp
    (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .msg_error_no_data_valid (opt.msg_error_no_data_valid),
        .busy_no_data_valid      (opt.busy_no_data_valid),
        .resp_done               (resp_done),
        .resp_info               (resp_info),
        .resp_valid              (resp_valid),
        .resp_invalid            (resp_invalid)
    );

    // The latch is transparent while both enables are high, so the last pin
    // value seen before either falls is the one kept.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_ff       <= '0;
            addr_valid_ff <= 1'b0;
        end
        else if (opt.address_latch_allow && address_latch_input)
        begin
            addr_ff       <= rt_addr_pins;
            addr_valid_ff <= 1'b1;
        end
    end

    assign rt_addr_latched = addr_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_bus_ff <= tcfg_pkg::BUS_A;
            seen_msg_ff <= 1'b0;
        end
        else if (monitor_mode && mon_msg_start)
        begin
            last_bus_ff <= mon_msg_bus;
            seen_msg_ff <= 1'b1;
        end
        else if (!monitor_mode)
            seen_msg_ff <= 1'b0;
    end

    assign alt_start = monitor_mode && mon_msg_start && seen_msg_ff && mon_msg_bus != last_bus_ff;

    // A new alternate-bus message restarts the extension even while one is
    // still running, which covers overlapping messages.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap_cnt_ff    <= '0;
            gap_active_ff <= 1'b0;
        end
        else if (alt_start && !opt.monitor_alt_bus_gap_keep)
        begin
            gap_cnt_ff    <= GAP_W'(GAP_EXT_CYCLES);
            gap_active_ff <= 1'b1;
        end
        else if (gap_cnt_ff != '0)
        begin
            gap_cnt_ff    <= gap_cnt_ff - GAP_W'(1);
            gap_active_ff <= gap_cnt_ff != GAP_W'(1);
        end
    end

    assign mon_gap_extend = gap_active_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            test_mode_ff <= tcfg_pkg::TM_NORMAL;
        else
            test_mode_ff <= test_decode(opt.test_select);
    end

    assign test_mode = test_mode_ff;

    AST_LATCH_CAPTURES: assert property (@(posedge pclk) disable iff (!presetn)
        opt.address_latch_allow && address_latch_input |=> rt_addr_latched == $past(rt_addr_pins))
        else $error("Address not latched with both enables high.");

    AST_LATCH_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        !opt.address_latch_allow |=> $stable(rt_addr_latched))
        else $error("Address latched while latch disabled.");

    AST_GAP_EXTEND_START: assert property (@(posedge pclk) disable iff (!presetn)
        alt_start && !opt.monitor_alt_bus_gap_keep |=> mon_gap_extend && gap_cnt_ff == GAP_W'(GAP_EXT_CYCLES))
        else $error("Alternate-bus gap extension did not start.");

    AST_GAP_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        !mon_gap_extend && !(alt_start && !opt.monitor_alt_bus_gap_keep) |=> !mon_gap_extend)
        else $error("Gap extended without an allowed alternate-bus message.");

    AST_GAP_LENGTH: assert property (@(posedge pclk) disable iff (!presetn)
        mon_gap_extend == (gap_cnt_ff != '0))
        else $error("Gap extension flag and counter disagree.");

    AST_TEST_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(opt.test_select) && opt.test_select == `TCFG_TEST_NORMAL |=> test_mode == tcfg_pkg::TM_NORMAL)
        else $error("Normal code did not select normal operation.");

    AST_TEST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
        opt.test_select[2:1] == 2'h3 |=> test_mode == tcfg_pkg::TM_INVALID)
        else $error("Reserved test code selected a test.");

    AST_TEST_REGS: assert property (@(posedge pclk) disable iff (!presetn)
        opt.test_select == `TCFG_TEST_REGISTERS |=> test_mode == tcfg_pkg::TM_REGISTERS)
        else $error("Register test code not decoded.");

endmodule
`default_nettype wire

//--- test/host_apb_model.sv
// Purpose: Host side APB master that writes and reads the terminal option registers.
// Assumes: Slave answers with pready; the wait is bounded only by the bench timeout.
// Notes:   Released data lines show the inverse of the last value so stale data is never mistaken for valid.
`timescale 1ns/1ps
`default_nettype none
module host_apb_model
(
    // Clock
    input  wire logic        pclk,
    // APB master
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata,
    output var  logic [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'h0;
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= w ? 4'hf : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
        paddr   <= ~a;
    endtask
endmodule
`default_nettype wire

//--- test/terminal_option_config_bench.sv
// Purpose: Self-checking bench for the terminal option register and its effects.
// Assumes: Gap extension shortened to 8 cycles through the top parameter.
// Notes:   Inputs change by non-blocking assignment at rising edges; outputs are sampled 1 ns later, or at the edge that ends an APB transfer.
`timescale 1ns/1ps
`include "tcfg_params.svh"
`default_nettype none
module terminal_option_config_bench;
    localparam int GAP = 8;
    logic                  pclk = 1'b0;
    logic                  presetn = 1'b0;
    logic                  psel, penable, pwrite, pready, pslverr;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, q, exp;
    logic [3:0]            pstrb;
    logic                  e, second_retry_req, second_retry_go, second_retry_drop;
    tcfg_pkg::bus_t        orig_bus, second_retry_bus, mon_msg_bus;
    logic                  resp_done, resp_valid, resp_invalid;
    tcfg_pkg::resp_info_t  resp_info;
    logic                  monitor_mode, mon_msg_start, mon_gap_extend, address_latch_input;
    tcfg_pkg::rt_addr_t    rt_addr_pins, rt_addr_latched;
    tcfg_pkg::test_mode_t  test_mode;
    int                    miscompares = 0;
    int                    cmp_count = 0;
    int                    cycles = 0;
    int                    n;
    int                    rc[5] = '{4, 0, 0, 0, 2};
    logic [1:0]            eb[5] = '{2'b10, 2'b10, 2'b01, 2'b11, 2'b00};

    always #12.5 pclk = ~pclk;

    host_apb_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    terminal_option_config #(.GAP_EXT_CYCLES(GAP)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .second_retry_req(second_retry_req), .orig_bus(orig_bus),
        .second_retry_go(second_retry_go), .second_retry_bus(second_retry_bus),
        .second_retry_drop(second_retry_drop), .resp_done(resp_done), .resp_info(resp_info),
        .resp_valid(resp_valid), .resp_invalid(resp_invalid), .monitor_mode(monitor_mode),
        .mon_msg_start(mon_msg_start), .mon_msg_bus(mon_msg_bus), .mon_gap_extend(mon_gap_extend),
        .address_latch_input(address_latch_input), .rt_addr_pins(rt_addr_pins),
        .rt_addr_latched(rt_addr_latched), .test_mode(test_mode));

    task automatic final_report();
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] seen);
        cmp_count++;
        if (seen !== ex)
        begin
            $display("wrong value %s expected %h seen %h", nm, ex, seen);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dq;
        logic        de;
        host.xfer(1'b1, a, d, dq, de);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask

    // A hang in any wait lands here instead of running forever.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    initial
    begin
        {second_retry_req, resp_done, monitor_mode, mon_msg_start, address_latch_input} = 5'h00;
        orig_bus = tcfg_pkg::BUS_A;
        mon_msg_bus = tcfg_pkg::BUS_A;
        resp_info = '0;
        rt_addr_pins = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        host.xfer(1'b0, `TCFG_OFS_OPTION, 32'h0, q, e);
        chk("option reset", 32'h0, q);
        host.xfer(1'b0, `TCFG_OFS_AUX, 32'h0, q, e);
        chk("aux reset", 32'h0, q);
        chk("test mode reset", 32'h01, 32'(test_mode));
        wr(`TCFG_OFS_OPTION, 32'h1234_a5c3);
        host.xfer(1'b0, `TCFG_OFS_OPTION, 32'h0, q, e);
        chk("option readback", 32'h0000_a5c3, q);
        host.xfer(1'b0, 12'h00c, 32'h0, q, e);
        chk("unmapped data", 32'h0, q);
        chk("unmapped error", 32'h1, 32'(e));
        for (int c = 0; c < 8; c++)
        begin
            wr(`TCFG_OFS_OPTION, 32'(c));
            tick(2);
            exp = (c < 6) ? (32'h1 << c) : 32'h40;
            chk("test mode", exp, 32'(test_mode));
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(`TCFG_OFS_OPTION, 32'(i % 2) << 7);
            wr(`TCFG_OFS_AUX, 32'((i / 2) % 2) << `TCFG_BIT_RETRY2_EN);
            @(posedge pclk);
            second_retry_req <= 1'b1;
            orig_bus <= tcfg_pkg::bus_t'(i / 4);
            @(posedge pclk);
            second_retry_req <= 1'b0;
            #1;
            chk("retry go", 32'((i / 2) % 2), 32'(second_retry_go));
            chk("retry drop", 32'(1 - (i / 2) % 2), 32'(second_retry_drop));
            if ((i / 2) % 2 == 1)
                chk("retry bus", 32'((i / 4) ^ (i % 2)), 32'(second_retry_bus));
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(`TCFG_OFS_OPTION, 32'(m) << 5);
            for (int j = 0; j < 5; j++)
            begin
                @(posedge pclk);
                resp_done <= 1'b1;
                resp_info <= '{6'd4, 6'(rc[j]), eb[j][1], eb[j][0]};
                @(posedge pclk);
                resp_done <= 1'b0;
                #1;
                exp = 32'(j == 0 || (j == 1 && m[1]) || (j == 2 && m[0]) || (j == 3 && m == 3));
                chk("resp valid", exp, 32'(resp_valid));
                chk("resp invalid", 32'(!exp[0]), 32'(resp_invalid));
            end
        end
        for (int k = 0; k < 2; k++)
        begin
            wr(`TCFG_OFS_OPTION, 32'(k) << 4);
            @(posedge pclk);
            monitor_mode <= 1'b1;
            for (int b = 0; b < 2; b++)
            begin
                @(posedge pclk);
                mon_msg_start <= 1'b1;
                mon_msg_bus <= tcfg_pkg::bus_t'(b);
                @(posedge pclk);
                mon_msg_start <= 1'b0;
            end
            n = 0;
            for (int t = 0; t < GAP + 4; t++)
            begin
                #1;
                n += int'(mon_gap_extend === 1'b1);
                @(posedge pclk);
            end
            monitor_mode <= 1'b0;
            chk("gap cycles", (k == 0) ? 32'(GAP) : 32'h0, 32'(n));
        end
        wr(`TCFG_OFS_OPTION, 32'h0);
        @(posedge pclk);
        rt_addr_pins <= 6'h2b;
        address_latch_input <= 1'b1;
        tick(3);
        chk("latch blocked", 32'h0, 32'(rt_addr_latched));
        wr(`TCFG_OFS_OPTION, 32'h08);
        tick(3);
        chk("latch taken", 32'h2b, 32'(rt_addr_latched));
        @(posedge pclk);
        address_latch_input <= 1'b0;
        rt_addr_pins <= 6'h15;
        tick(3);
        chk("latch held", 32'h2b, 32'(rt_addr_latched));
        host.xfer(1'b0, `TCFG_OFS_STATUS, 32'h0, q, e);
        chk("status", 32'h0000_006b, q);
        final_report();
    end
endmodule
`default_nettype wire
